// ### rtl/cpf_pkg.sv
// Constants and types for the codec port status and flag block
package cpf_pkg;
  localparam int CNT_W = 4;
  localparam int SAMPLE_W = 16;
  localparam int CADDR_W = 4;
  localparam int CDATA_W = 16;
  localparam int CWORD_W = 21;
  localparam int BIT_IDX_W = 8;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 4'h8;
  localparam logic [CNT_W-1:0] FIFO_EMPTY = 4'h0;
  localparam logic [CNT_W-1:0] RX_SRV_ON_LVL = 4'h6;
  localparam logic [CNT_W-1:0] TX_SRV_ON_LVL = 4'h4;
  localparam int DATA_LSB = 0;
  localparam int RW_BIT = 16;
  localparam int ADDR_LSB = 17;
  localparam logic [CADDR_W-1:0] AUDIO_CTRL_B_ADDR = 4'h8;
  localparam int ENA_IN_BIT = 14;
  localparam int ENA_OUT_BIT = 15;
  localparam logic [BIT_IDX_W-1:0] FRAME_FIRST_BIT = 8'h01;
  localparam logic [BIT_IDX_W-1:0] FRAME_LAST_BIT = 8'h80;
  localparam logic [BIT_IDX_W-1:0] READ_LOAD_BIT = 8'h29;
  localparam logic [BIT_IDX_W-1:0] RET_CAPTURE_BIT = 8'h39;
  localparam logic [BIT_IDX_W-1:0] WRITE_LATCH_BIT = 8'h41;
  localparam int W1C_AUDIO_UNDERRUN = 0;
  localparam int W1C_AUDIO_OVERRUN = 1;
  localparam int W1C_TELECOM_UNDERRUN = 2;
  localparam int W1C_TELECOM_OVERRUN = 3;

  typedef enum logic [2:0] {
    CS_IDLE,
    CS_WAIT_FRAME,
    CS_READ_RETURN,
    CS_WRITE_LATCH,
    CS_WRITE_ECHO_WAIT,
    CS_WRITE_RETURN
  } cpf_codec_state_t;

  typedef struct packed {
    logic tx_srv;
    logic rx_srv;
    logic underrun;
    logic overrun;
    logic tx_nf;
    logic rx_ne;
    logic [SAMPLE_W-1:0] tx_sample;
    logic rx_wr;
    logic [SAMPLE_W-1:0] rx_data;
    logic irq;
  } cpf_path_state_t;
endpackage

// ### rtl/cpf_path_if.sv
// Signals between the top and one FIFO status path
`timescale 1ns/1ns
interface cpf_path_if;
  logic port_enable;
  logic [cpf_pkg::CNT_W-1:0] tx_count;
  logic [cpf_pkg::CNT_W-1:0] rx_count;
  logic tx_fetch;
  logic [cpf_pkg::SAMPLE_W-1:0] tx_head;
  logic rx_push;
  logic [cpf_pkg::SAMPLE_W-1:0] rx_sample;
  logic tx_mask;
  logic rx_mask;
  logic underrun_clr;
  logic overrun_clr;
  logic tx_srv;
  logic rx_srv;
  logic underrun;
  logic overrun;
  logic tx_nf;
  logic rx_ne;
  logic [cpf_pkg::SAMPLE_W-1:0] tx_sample;
  logic rx_wr;
  logic [cpf_pkg::SAMPLE_W-1:0] rx_data;
  logic irq;
  modport ctrl (
    output port_enable, tx_count, rx_count, tx_fetch, tx_head, rx_push, rx_sample,
    output tx_mask, rx_mask, underrun_clr, overrun_clr,
    input tx_srv, rx_srv, underrun, overrun, tx_nf, rx_ne, tx_sample, rx_wr, rx_data, irq
  );
  modport path (
    input port_enable, tx_count, rx_count, tx_fetch, tx_head, rx_push, rx_sample,
    input tx_mask, rx_mask, underrun_clr, overrun_clr,
    output tx_srv, rx_srv, underrun, overrun, tx_nf, rx_ne, tx_sample, rx_wr, rx_data, irq
  );
endinterface

// ### rtl/cpf_path.sv
// Status flags, sticky errors and sample hold for one FIFO path
`timescale 1ns/1ns
module cpf_path #(
  parameter bit HAS_TX_SRV = 1'b1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  cpf_path_if.path p
);
  cpf_pkg::cpf_path_state_t s;
  cpf_pkg::cpf_path_state_t next_s;

  always_comb begin
    logic under_evt;
    logic over_evt;
    under_evt = p.tx_fetch && (p.tx_count == cpf_pkg::FIFO_EMPTY);
    over_evt = p.rx_push && (p.rx_count == cpf_pkg::FIFO_DEPTH);
    next_s = s;
    // Service flags from fill level, zero while disabled
    next_s.tx_srv = HAS_TX_SRV && p.port_enable
                    && (p.tx_count <= cpf_pkg::TX_SRV_ON_LVL);
    next_s.rx_srv = p.port_enable && (p.rx_count >= cpf_pkg::RX_SRV_ON_LVL);
    next_s.tx_nf = (p.tx_count != cpf_pkg::FIFO_DEPTH);
    next_s.rx_ne = (p.rx_count != cpf_pkg::FIFO_EMPTY);
    // Sticky errors, set wins over clear
    next_s.underrun = (s.underrun && !p.underrun_clr) || under_evt;
    next_s.overrun = (s.overrun && !p.overrun_clr) || over_evt;
    // Last valid sample repeats while empty
    if (p.tx_fetch && !under_evt) begin
      next_s.tx_sample = p.tx_head;
    end
    // Arrivals into a full FIFO are dropped
    next_s.rx_wr = p.rx_push && !over_evt;
    if (p.rx_push) begin
      next_s.rx_data = p.rx_sample;
    end
    next_s.irq = (next_s.tx_srv && p.tx_mask) || (next_s.rx_srv && p.rx_mask)
                 || next_s.underrun || next_s.overrun;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{tx_srv: 1'b0, rx_srv: 1'b0, underrun: 1'b0, overrun: 1'b0, tx_nf: 1'b1,
             rx_ne: 1'b0, tx_sample: '0, rx_wr: 1'b0, rx_data: '0, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign p.tx_srv = s.tx_srv;
  assign p.rx_srv = s.rx_srv;
  assign p.underrun = s.underrun;
  assign p.overrun = s.overrun;
  assign p.tx_nf = s.tx_nf;
  assign p.rx_ne = s.rx_ne;
  assign p.tx_sample = s.tx_sample;
  assign p.rx_wr = s.rx_wr;
  assign p.rx_data = s.rx_data;
  assign p.irq = s.irq;
endmodule

// ### rtl/cpf_top.sv
// Codec serial port status flags, codec access sequencing and enable tracking
// Functional notes
// - Audio receive service flag on at six or more entries, off at five or fewer.
// - Audio receive service flag requests interrupt unless its mask bit is clear.
// - Telecom transmit service flag on at four or fewer entries, off at five.
// - Telecom transmit service flag requests interrupt unless its mask bit is clear.
// - Telecom receive service flag on at six or more entries, off at five.
// - Telecom receive service flag requests interrupt unless its mask bit is clear.
// - Fetch from empty audio transmit FIFO sets audio underrun, unmaskable interrupt.
// - During audio underrun the last valid sample repeats until new data arrives.
// - Audio sample into full receive FIFO is dropped and sets audio overrun.
// - Telecom empty fetch sets telecom underrun and repeats last valid sample.
// - Telecom sample into full receive FIFO is dropped and sets telecom overrun.
// - Audio transmit not-full high while any entry free; no interrupt.
// - Audio receive not-empty high while any entry valid; no interrupt.
// - Telecom transmit not-full high while any entry free; no interrupt.
// - Telecom receive not-empty high while any entry valid; no interrupt.
// - Codec write: sent in subframe 0, latched bit 65, echo next subframe 0.
// - Codec read: sent in subframe 0, loaded bit 41, returned same subframe 0.
// - Any software access to codec data register clears both done flags.
// - Write to codec register 8 with bit 14 or 15 sets enabled flag.
// - Same write sequence with both enable bits clear clears the enabled flag.
// - Sticky bits clear on writing one; zero writes and read-only writes ignored.
// - Interrupt request stays up while its bit is set, drops on clear.
// - Service flags read zero while the codec port is disabled.
`timescale 1ns/1ns
module cpf_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic port_enable,
  input wire logic audio_rx_irq_mask,
  input wire logic telecom_tx_irq_mask,
  input wire logic telecom_rx_irq_mask,
  input wire logic [3:0] status_clear_w1c,
  input wire logic [cpf_pkg::CNT_W-1:0] audio_tx_count,
  input wire logic [cpf_pkg::CNT_W-1:0] audio_rx_count,
  input wire logic [cpf_pkg::CNT_W-1:0] telecom_tx_count,
  input wire logic [cpf_pkg::CNT_W-1:0] telecom_rx_count,
  input wire logic audio_tx_fetch,
  input wire logic [cpf_pkg::SAMPLE_W-1:0] audio_tx_head,
  input wire logic telecom_tx_fetch,
  input wire logic [cpf_pkg::SAMPLE_W-1:0] telecom_tx_head,
  input wire logic audio_rx_push,
  input wire logic [cpf_pkg::SAMPLE_W-1:0] audio_rx_sample,
  input wire logic telecom_rx_push,
  input wire logic [cpf_pkg::SAMPLE_W-1:0] telecom_rx_sample,
  input wire logic codec_access_data_reg_wr,
  input wire logic [cpf_pkg::CWORD_W-1:0] codec_access_data_reg_wdata,
  input wire logic codec_access_data_reg_rd,
  input wire logic frame_sync,
  input wire logic bit_tick,
  input wire logic rx_bit,
  output logic [cpf_pkg::CWORD_W-1:0] codec_access_data_reg_rdata,
  output logic codec_cmd_send,
  output logic [cpf_pkg::CWORD_W-1:0] codec_cmd_word,
  output logic codec_write_done,
  output logic codec_read_done,
  output logic audio_codec_enabled,
  output logic audio_rx_service_flag,
  output logic telecom_tx_service_flag,
  output logic telecom_rx_service_flag,
  output logic audio_tx_underrun_status,
  output logic audio_rx_overrun_status,
  output logic telecom_tx_underrun_status,
  output logic telecom_rx_overrun_status,
  output logic audio_tx_not_full,
  output logic audio_rx_not_empty,
  output logic telecom_tx_not_full,
  output logic telecom_rx_not_empty,
  output logic [cpf_pkg::SAMPLE_W-1:0] audio_tx_sample,
  output logic [cpf_pkg::SAMPLE_W-1:0] telecom_tx_sample,
  output logic audio_rx_write,
  output logic [cpf_pkg::SAMPLE_W-1:0] audio_rx_write_data,
  output logic telecom_rx_write,
  output logic [cpf_pkg::SAMPLE_W-1:0] telecom_rx_write_data,
  output logic audio_irq,
  output logic telecom_irq
);
  typedef struct packed {
    cpf_pkg::cpf_codec_state_t cs;
    logic [cpf_pkg::BIT_IDX_W-1:0] bit_idx;
    logic [cpf_pkg::CWORD_W-2:0] rx_shift;
    logic [cpf_pkg::CWORD_W-1:0] cmd;
    logic [cpf_pkg::CWORD_W-1:0] rdata;
    logic send;
    logic wr_done;
    logic rd_done;
    logic ace_pending;
    logic ace_value;
    logic ace;
  } cpf_top_state_t;

  cpf_top_state_t s;
  cpf_top_state_t next_s;

  // Index 0 is audio, index 1 is telecom
  cpf_path_if pif[2] ();

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_path
      cpf_path #(.HAS_TX_SRV(gi == 1)) u_path (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .p(pif[gi].path)
      );
      assign pif[gi].port_enable = port_enable;
    end
  endgenerate

  assign pif[0].tx_count = audio_tx_count;
  assign pif[0].rx_count = audio_rx_count;
  assign pif[0].tx_fetch = audio_tx_fetch;
  assign pif[0].tx_head = audio_tx_head;
  assign pif[0].rx_push = audio_rx_push;
  assign pif[0].rx_sample = audio_rx_sample;
  assign pif[0].tx_mask = 1'b0;
  assign pif[0].rx_mask = audio_rx_irq_mask;
  assign pif[0].underrun_clr = status_clear_w1c[cpf_pkg::W1C_AUDIO_UNDERRUN];
  assign pif[0].overrun_clr = status_clear_w1c[cpf_pkg::W1C_AUDIO_OVERRUN];
  assign pif[1].tx_count = telecom_tx_count;
  assign pif[1].rx_count = telecom_rx_count;
  assign pif[1].tx_fetch = telecom_tx_fetch;
  assign pif[1].tx_head = telecom_tx_head;
  assign pif[1].rx_push = telecom_rx_push;
  assign pif[1].rx_sample = telecom_rx_sample;
  assign pif[1].tx_mask = telecom_tx_irq_mask;
  assign pif[1].rx_mask = telecom_rx_irq_mask;
  assign pif[1].underrun_clr = status_clear_w1c[cpf_pkg::W1C_TELECOM_UNDERRUN];
  assign pif[1].overrun_clr = status_clear_w1c[cpf_pkg::W1C_TELECOM_OVERRUN];

  // Bit index of the current tick within the frame
  function automatic logic [cpf_pkg::BIT_IDX_W-1:0] tick_index(
    input logic sync,
    input logic [cpf_pkg::BIT_IDX_W-1:0] idx
  );
    if (sync) begin
      return cpf_pkg::FRAME_FIRST_BIT;
    end else if (idx == cpf_pkg::FRAME_LAST_BIT) begin
      return idx;
    end else begin
      return idx + cpf_pkg::FRAME_FIRST_BIT;
    end
  endfunction

  always_comb begin
    logic [cpf_pkg::BIT_IDX_W-1:0] cur;
    logic [cpf_pkg::CWORD_W-2:0] shifted;
    logic sw_touch;
    logic set_wr;
    logic set_rd;
    logic is_ena_reg;
    cur = tick_index(frame_sync, s.bit_idx);
    shifted = {s.rx_shift[cpf_pkg::CWORD_W-3:0], rx_bit};
    sw_touch = codec_access_data_reg_wr || codec_access_data_reg_rd;
    set_wr = 1'b0;
    set_rd = 1'b0;
    is_ena_reg = (s.cmd[cpf_pkg::ADDR_LSB +: cpf_pkg::CADDR_W] == cpf_pkg::AUDIO_CTRL_B_ADDR);
    next_s = s;
    if (bit_tick) begin
      next_s.bit_idx = cur;
      next_s.rx_shift = shifted;
    end
    // Enable flag follows a latched register 8 write at the next frame sync
    if (frame_sync && s.ace_pending) begin
      next_s.ace = s.ace_value;
      next_s.ace_pending = 1'b0;
    end
    unique case (s.cs)
      cpf_pkg::CS_IDLE: begin
        next_s.send = 1'b0;
        if (codec_access_data_reg_wr) begin
          next_s.cmd = codec_access_data_reg_wdata;
          next_s.cs = cpf_pkg::CS_WAIT_FRAME;
        end
      end
      cpf_pkg::CS_WAIT_FRAME: begin
        if (bit_tick && frame_sync) begin
          next_s.send = 1'b1;
          next_s.cs = s.cmd[cpf_pkg::RW_BIT] ? cpf_pkg::CS_WRITE_LATCH
                                             : cpf_pkg::CS_READ_RETURN;
        end
      end
      cpf_pkg::CS_READ_RETURN: begin
        if (bit_tick && cur == cpf_pkg::READ_LOAD_BIT) begin
          next_s.send = 1'b0;
        end
        if (bit_tick && cur == cpf_pkg::RET_CAPTURE_BIT) begin
          next_s.rdata = {shifted[cpf_pkg::CWORD_W-2:cpf_pkg::CDATA_W], 1'b0,
                          shifted[cpf_pkg::CDATA_W-1:0]};
          set_rd = 1'b1;
          next_s.cs = cpf_pkg::CS_IDLE;
        end
      end
      cpf_pkg::CS_WRITE_LATCH: begin
        if (bit_tick && cur == cpf_pkg::WRITE_LATCH_BIT) begin
          next_s.send = 1'b0;
          if (is_ena_reg) begin
            next_s.ace_pending = 1'b1;
            next_s.ace_value = s.cmd[cpf_pkg::ENA_IN_BIT] || s.cmd[cpf_pkg::ENA_OUT_BIT];
          end
          next_s.cs = cpf_pkg::CS_WRITE_ECHO_WAIT;
        end
      end
      cpf_pkg::CS_WRITE_ECHO_WAIT: begin
        if (bit_tick && frame_sync) begin
          next_s.cs = cpf_pkg::CS_WRITE_RETURN;
        end
      end
      cpf_pkg::CS_WRITE_RETURN: begin
        if (bit_tick && cur == cpf_pkg::RET_CAPTURE_BIT) begin
          next_s.rdata = {shifted[cpf_pkg::CWORD_W-2:cpf_pkg::CDATA_W], 1'b0,
                          shifted[cpf_pkg::CDATA_W-1:0]};
          set_wr = 1'b1;
          next_s.cs = cpf_pkg::CS_IDLE;
        end
      end
      default: begin
        next_s.cs = cpf_pkg::CS_IDLE;
      end
    endcase
    // Done flags clear on access, set wins
    next_s.wr_done = (s.wr_done && !sw_touch) || set_wr;
    next_s.rd_done = (s.rd_done && !sw_touch) || set_rd;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{cs: cpf_pkg::CS_IDLE, bit_idx: cpf_pkg::FRAME_LAST_BIT, rx_shift: '0,
             cmd: '0, rdata: '0, send: 1'b0, wr_done: 1'b0, rd_done: 1'b0,
             ace_pending: 1'b0, ace_value: 1'b0, ace: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign codec_access_data_reg_rdata = s.rdata;
  assign codec_cmd_send = s.send;
  assign codec_cmd_word = s.cmd;
  assign codec_write_done = s.wr_done;
  assign codec_read_done = s.rd_done;
  assign audio_codec_enabled = s.ace;
  assign audio_rx_service_flag = pif[0].rx_srv;
  assign telecom_tx_service_flag = pif[1].tx_srv;
  assign telecom_rx_service_flag = pif[1].rx_srv;
  assign audio_tx_underrun_status = pif[0].underrun;
  assign audio_rx_overrun_status = pif[0].overrun;
  assign telecom_tx_underrun_status = pif[1].underrun;
  assign telecom_rx_overrun_status = pif[1].overrun;
  assign audio_tx_not_full = pif[0].tx_nf;
  assign audio_rx_not_empty = pif[0].rx_ne;
  assign telecom_tx_not_full = pif[1].tx_nf;
  assign telecom_rx_not_empty = pif[1].rx_ne;
  assign audio_tx_sample = pif[0].tx_sample;
  assign telecom_tx_sample = pif[1].tx_sample;
  assign audio_rx_write = pif[0].rx_wr;
  assign audio_rx_write_data = pif[0].rx_data;
  assign telecom_rx_write = pif[1].rx_wr;
  assign telecom_rx_write_data = pif[1].rx_data;
  assign audio_irq = pif[0].irq;
  assign telecom_irq = pif[1].irq;
endmodule

// ### verif/cpf_monitor.sv
// Concurrent checks on the codec port status block
`timescale 1ns/1ns
module cpf_monitor (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic port_enable,
  input wire logic [3:0] status_clear_w1c,
  input wire logic [cpf_pkg::CNT_W-1:0] audio_tx_count,
  input wire logic [cpf_pkg::CNT_W-1:0] audio_rx_count,
  input wire logic audio_tx_fetch,
  input wire logic audio_rx_push,
  input wire logic codec_access_data_reg_wr,
  input wire logic codec_access_data_reg_rd,
  input wire logic frame_sync,
  input wire logic codec_cmd_send,
  input wire logic codec_write_done,
  input wire logic codec_read_done,
  input wire logic audio_codec_enabled,
  input wire logic audio_rx_service_flag,
  input wire logic audio_tx_underrun_status,
  input wire logic audio_rx_overrun_status,
  input wire logic [cpf_pkg::SAMPLE_W-1:0] audio_tx_sample,
  input wire logic audio_rx_write,
  input wire logic audio_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Command starts right after a frame start and ends within 300 cycles
  sequence s_send_rise;
    $rose(codec_cmd_send);
  endsequence
  sequence s_send_body;
    ($past(frame_sync) || $past(frame_sync, 2)) ##[1:300] !codec_cmd_send;
  endsequence
  AST_ARX_SRV: assert property (1'b1 |=>
    audio_rx_service_flag == $past(port_enable && audio_rx_count >= 4'h6))
    else $error("rx service flag wrong");
  AST_AIRQ_OFF: assert property (
    !audio_rx_service_flag && !audio_tx_underrun_status && !audio_rx_overrun_status |-> !audio_irq)
    else $error("audio irq without cause");
  AST_AUND: assert property (audio_tx_fetch && audio_tx_count == 4'h0 |=>
    audio_tx_underrun_status && $stable(audio_tx_sample)) else $error("underrun handling wrong");
  AST_AOVR: assert property (audio_rx_push && audio_rx_count == 4'h8 |=>
    audio_rx_overrun_status && !audio_rx_write) else $error("overrun handling wrong");
  AST_STICKY: assert property (
    audio_tx_underrun_status && !status_clear_w1c[0] |=> audio_tx_underrun_status)
    else $error("sticky bit lost");
  // A raised flag means idle, so no set can coincide and win
  AST_DONE_CLR: assert property (
    (codec_access_data_reg_rd || codec_access_data_reg_wr)
    && (codec_write_done || codec_read_done) |=> !codec_write_done && !codec_read_done)
    else $error("done flag not cleared");
  AST_CMD: assert property (s_send_rise |-> s_send_body)
    else $error("command framing wrong");
  AST_ENA: assert property (!$stable(audio_codec_enabled) |->
    $past(frame_sync) || $past(frame_sync, 2)) else $error("enable flag off frame");
endmodule
bind cpf_top cpf_monitor u_mon (.*);

// ### verif/cpf_codec_model.sv
// Behavioural codec on the framed serial link
`timescale 1ns/1ns
module cpf_codec_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic codec_cmd_send,
  input wire logic [cpf_pkg::CWORD_W-1:0] codec_cmd_word,
  output logic frame_sync,
  output logic bit_tick,
  output logic rx_bit
);
  logic [15:0] regs [16];
  logic [7:0] idx;
  logic wr_pend;
  logic [3:0] addr;
  logic [15:0] wval;
  logic [19:0] ret;
  assign frame_sync = bit_tick && idx == 8'h01;
  // Return field on bits 38 to 57, changing filler elsewhere
  assign rx_bit = (idx >= 8'h26 && idx <= 8'h39) ? ret[5'(8'h39 - idx)] : idx[0];
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_tick <= 1'b0;
      idx <= 8'h01;
      wr_pend <= 1'b0;
      addr <= 4'h0;
      wval <= 16'h0000;
      ret <= 20'h00000;
      regs <= '{default: 16'h0000};
    end else begin
      bit_tick <= !bit_tick;
      if (bit_tick) begin
        idx <= (idx == 8'h80) ? 8'h01 : idx + 8'h01;
        if (idx == 8'h02 && codec_cmd_send) begin
          addr <= codec_cmd_word[20:17];
          wval <= codec_cmd_word[15:0];
          wr_pend <= codec_cmd_word[16];
          ret[19:16] <= codec_cmd_word[20:17];
        end
        if (idx == 8'h29 && !wr_pend) ret[15:0] <= regs[ret[19:16]];
        if (idx == 8'h41 && wr_pend) begin
          regs[addr] <= wval;
          ret[15:0] <= wval;
          wr_pend <= 1'b0;
        end
      end
    end
  end
endmodule

// ### verif/codec_port_status_flags_tb_top.sv
// Self-checking bench for the codec port status block
`timescale 1ns/1ns
module codec_port_status_flags_tb_top;
  logic ref_clk, arst_n, port_enable, audio_rx_irq_mask, telecom_tx_irq_mask, telecom_rx_irq_mask;
  logic codec_access_data_reg_wr, codec_access_data_reg_rd;
  logic [3:0] status_clear_w1c;
  logic [cpf_pkg::CWORD_W-1:0] codec_access_data_reg_wdata;
  wire logic frame_sync, bit_tick, rx_bit, codec_cmd_send;
  wire logic codec_write_done, codec_read_done, audio_codec_enabled;
  wire logic [cpf_pkg::CWORD_W-1:0] codec_access_data_reg_rdata, codec_cmd_word;
  logic [3:0] cnt [4];
  logic [15:0] head [2];
  logic [15:0] smp [2];
  logic [1:0] fetch, push;
  wire logic [15:0] txs [2];
  wire logic [15:0] rxd [2];
  wire logic [1:0] und, ovr, irq, rxw;
  wire logic [2:0] srv;
  wire logic [3:0] nfne;
  logic [20:0] ops [6] = '{21'h114000, 21'h100000, 21'h118000, 21'h113fff, 21'h07c003, 21'h060000};
  logic [20:0] rets [6] = '{21'h104000, 21'h104000, 21'h108000, 21'h103fff, 21'h06c003, 21'h06c003};
  logic [5:0] enas = 6'h07;
  int mismatches = 0;
  int total_checks = 0;
  cpf_top uut (.audio_tx_count(cnt[0]), .audio_rx_count(cnt[1]), .telecom_tx_count(cnt[2]),
    .telecom_rx_count(cnt[3]), .audio_tx_fetch(fetch[0]), .telecom_tx_fetch(fetch[1]),
    .audio_tx_head(head[0]), .telecom_tx_head(head[1]), .audio_rx_push(push[0]),
    .telecom_rx_push(push[1]), .audio_rx_sample(smp[0]), .telecom_rx_sample(smp[1]),
    .audio_rx_service_flag(srv[0]), .telecom_tx_service_flag(srv[1]),
    .telecom_rx_service_flag(srv[2]), .audio_tx_underrun_status(und[0]),
    .telecom_tx_underrun_status(und[1]), .audio_rx_overrun_status(ovr[0]),
    .telecom_rx_overrun_status(ovr[1]), .audio_tx_not_full(nfne[0]), .audio_rx_not_empty(nfne[1]),
    .telecom_tx_not_full(nfne[2]), .telecom_rx_not_empty(nfne[3]), .audio_tx_sample(txs[0]),
    .telecom_tx_sample(txs[1]), .audio_rx_write(rxw[0]), .telecom_rx_write(rxw[1]),
    .audio_rx_write_data(rxd[0]), .telecom_rx_write_data(rxd[1]), .audio_irq(irq[0]),
    .telecom_irq(irq[1]), .*);
  cpf_codec_model u_codec (.*);
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One codec access, waits for its done flag
  task automatic codec(input logic [20:0] w);
    int n;
    n = 0;
    codec_access_data_reg_wdata = w;
    codec_access_data_reg_wr = 1'b1;
    step(1);
    codec_access_data_reg_wr = 1'b0;
    chk({codec_write_done, codec_read_done}, 21'h0);
    while ((w[16] ? codec_write_done : codec_read_done) !== 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
    if (n == 1000) begin
      mismatches++;
      end_sim();
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    arst_n = 1'b0;
    port_enable = 1'b0;
    {audio_rx_irq_mask, telecom_tx_irq_mask, telecom_rx_irq_mask} = 3'h0;
    status_clear_w1c = 4'h0;
    codec_access_data_reg_wr = 1'b0;
    codec_access_data_reg_rd = 1'b0;
    codec_access_data_reg_wdata = 21'h0;
    fetch = 2'h0;
    push = 2'h0;
    cnt = '{4'h0, 4'h0, 4'h0, 4'h0};
    head = '{16'h0000, 16'h0000};
    smp = '{16'h0000, 16'h0000};
    step(10);
    chk(nfne, 21'h5);
    chk({srv, und, ovr, irq}, 21'h0);
    chk({codec_write_done, codec_read_done, audio_codec_enabled}, 21'h0);
    arst_n = 1'b1;
    // Fill level sweep, port off then on, masks open on odd levels
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c <= 8; c++) begin
        port_enable = e[0];
        {audio_rx_irq_mask, telecom_tx_irq_mask, telecom_rx_irq_mask} = {3{c[0]}};
        cnt = '{4'(c), 4'(c), 4'(c), 4'(c)};
        step(1);
        chk(srv, {e == 1 && c >= 6, e == 1 && c <= 4, e == 1 && c >= 6});
        chk(nfne, {c != 0, c != 8, c != 0, c != 8});
        chk(irq, {c[0] && e == 1 && c != 5, c[0] && e == 1 && c >= 6});
      end
    end
    {audio_rx_irq_mask, telecom_tx_irq_mask, telecom_rx_irq_mask} = 3'h0;
    cnt = '{4'h5, 4'h5, 4'h5, 4'h5};
    for (int p = 0; p < 2; p++) begin
      // Valid fetch then two fetches from empty, back to back
      cnt[2 * p] = 4'h1;
      head[p] = 16'h1230 + 16'(p);
      fetch[p] = 1'b1;
      step(1);
      cnt[2 * p] = 4'h0;
      head[p] = 16'hdead;
      step(2);
      chk({und, irq[p], txs[p]}, {2'(1 << p), 1'b1, 16'h1230 + 16'(p)});
      cnt[2 * p] = 4'h3;
      head[p] = 16'hbee0 + 16'(p);
      step(1);
      fetch[p] = 1'b0;
      chk(txs[p], 16'hbee0 + 16'(p));
      // Arrival into a full receive FIFO, then one with room
      cnt[2 * p + 1] = 4'h8;
      smp[p] = 16'h0bad;
      push[p] = 1'b1;
      step(1);
      chk({ovr, rxw}, {2'(1 << p), 2'h0});
      cnt[2 * p + 1] = 4'h7;
      smp[p] = 16'h5a50 + 16'(p);
      step(1);
      push[p] = 1'b0;
      chk({rxw[p], rxd[p]}, {1'b1, 16'h5a50 + 16'(p)});
      status_clear_w1c = 4'(12 >> (2 * p));
      step(3);
      chk({und[p], ovr[p], irq[p]}, 21'h7);
      status_clear_w1c = 4'(3 << (2 * p));
      step(1);
      status_clear_w1c = 4'h0;
      chk({und, ovr, irq}, 21'h0);
    end
    // Codec accesses; even steps leave done set for the next write to clear
    port_enable = 1'b1;
    for (int i = 0; i < 6; i++) begin
      codec(ops[i]);
      chk(codec_access_data_reg_rdata, rets[i]);
      chk(audio_codec_enabled, enas[i]);
      if (i[0]) begin
        codec_access_data_reg_rd = 1'b1;
        step(1);
        codec_access_data_reg_rd = 1'b0;
        chk({codec_write_done, codec_read_done}, 21'h0);
      end
    end
    end_sim();
  end
endmodule
